//--- design/regmap_pkg.sv
// Purpose: shared constants of the compatible holding-register bank
// Assumes: register numbers are 16-bit word addresses on the fieldbus
// Notes:   32-bit values place the high word at the lower register number

package regmap_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ        = 50_000_000; // core clock rate
    localparam int unsigned UPDATE_MS     = 110;        // refresh period in ms
    // refresh period in clock cycles, rounded down
    localparam int unsigned UPDATE_CYCLES = (CLK_HZ / 1000) * UPDATE_MS;

    // ************************************************************
    // register-type codes
    // ************************************************************
    localparam logic [15:0] LAYOUT_NATIVE = 16'h0000; // served elsewhere
    localparam logic [15:0] LAYOUT_ALT1   = 16'h0001; // first compatible map
    localparam logic [15:0] LAYOUT_ALT2   = 16'h0002; // second compatible map

    // ************************************************************
    // address ranges
    // ************************************************************
    localparam logic [15:0] LAYOUT_LAST   = 16'h0031; // last switched register
    localparam logic [15:0] RSV_FIRST     = 16'h0032; // first reserved register
    localparam logic [15:0] RSV_LAST      = 16'h005f; // last reserved register
    localparam logic [15:0] MAKER_HI_IDX  = 16'h0060; // maker chars 0,1
    localparam logic [15:0] MAKER_LO_IDX  = 16'h0061; // maker chars 2,3
    localparam logic [15:0] FW_REV_IDX    = 16'h0062; // firmware revision
    localparam logic [15:0] HW_REV_IDX    = 16'h0063; // hardware revision

    // ************************************************************
    // first compatible layout
    // ************************************************************
    localparam logic [15:0] A1_CONST_A_IDX   = 16'h0000;
    localparam logic [15:0] A1_CONST_B_IDX   = 16'h0001;
    localparam logic [15:0] A1_CONST_C_IDX   = 16'h0002;
    localparam logic [15:0] A1_CONST_E_IDX   = 16'h0004;
    localparam logic [15:0] A1_COMP_IDX      = 16'h0005;
    localparam logic [15:0] A1_RAW_IDX       = 16'h0006;
    localparam logic [15:0] A1_SUPPLY_IDX    = 16'h0009;
    localparam logic [15:0] A1_DET_HI_IDX    = 16'h0012;
    localparam logic [15:0] A1_DET_LO_IDX    = 16'h0013;
    localparam logic [15:0] A1_YEAR_IDX      = 16'h0029;
    localparam logic [15:0] A1_FW_IDX        = 16'h002b;
    localparam logic [15:0] A1_HW_IDX        = 16'h002c;
    localparam logic [15:0] A1_ADDR_IDX      = 16'h002d;
    localparam logic [15:0] A1_CONST_A_VAL   = 16'hffff;
    localparam logic [15:0] A1_CONST_B_VAL   = 16'h0064;
    localparam logic [15:0] A1_CONST_C_VAL   = 16'h0001;
    localparam logic [15:0] A1_CONST_E_VAL   = 16'h0001;
    localparam logic [15:0] A1_YEAR_VAL      = 16'h07e4;

    // ************************************************************
    // second compatible layout
    // ************************************************************
    localparam logic [15:0] A2_ADDR_IDX      = 16'h0000;
    localparam logic [15:0] A2_LINK_IDX      = 16'h0001;
    localparam logic [15:0] A2_COMP_HI_IDX   = 16'h0002;
    localparam logic [15:0] A2_COMP_LO_IDX   = 16'h0003;
    localparam logic [15:0] A2_RAW_HI_IDX    = 16'h0004;
    localparam logic [15:0] A2_RAW_LO_IDX    = 16'h0005;
    localparam logic [15:0] A2_HUND_A_IDX    = 16'h0008;
    localparam logic [15:0] A2_HUND_B_IDX    = 16'h0009;
    localparam logic [15:0] A2_DET_HI_IDX    = 16'h000a;
    localparam logic [15:0] A2_DET_LO_IDX    = 16'h000b;
    localparam logic [15:0] A2_NAME_FIRST    = 16'h0020;
    localparam logic [15:0] A2_NAME_LAST     = 16'h0027;
    localparam logic [15:0] A2_SENS_HI_IDX   = 16'h0029;
    localparam logic [15:0] A2_SENS_LO_IDX   = 16'h002a;
    localparam logic [15:0] A2_CAL_HI_IDX    = 16'h002e;
    localparam logic [15:0] A2_CAL_LO_IDX    = 16'h002f;
    localparam logic [15:0] A2_HUNDRED_VAL   = 16'h0064;

    // ************************************************************
    // identity words (arbitrary neutral values)
    // ************************************************************
    localparam logic [31:0] MAKER_NAME_VAL   = 32'h4142_4320; // arbitrary
    localparam logic [15:0] FW_REV_VAL       = 16'h0001;      // arbitrary
    localparam logic [15:0] HW_REV_VAL       = 16'h0001;      // arbitrary

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] ZERO16           = 16'h0000;
    localparam logic [31:0] ZERO32           = 32'h0000_0000;

endpackage

//--- design/compat_regbank.sv
// Purpose: read-only holding registers 0-99 in the two compatible layouts
// Assumes: a fieldbus engine issues one-cycle read and write strobes
// Notes:   measurement inputs are sampled into a snapshot once per period
//
// Contract
// RULE_01: measurements refresh by themselves about every 110 ms
// RULE_02: reads between refreshes return the same value
// RULE_03: host should poll no faster than 110 ms
// RULE_04: unassigned addresses read unsigned 16-bit zero
// RULE_05: registers 50 to 95 read zero
// RULE_06: registers 96-97 hold four-character maker name
// RULE_07: registers 98 and 99 give firmware, hardware revision
// RULE_08: first layout constants at 0-4, zeros elsewhere
// RULE_09: first layout measurement words at 5,6,9,18-19
// RULE_10: first layout year, revisions, address at 41-45
// RULE_11: second layout address, link, irradiance, constants
// RULE_12: register-type setting picks the layout of 0-49
// RULE_13: registers 0-99 ignore host writes
// RULE_14: two-word values latch together at each refresh; sensitivity and calibration date are read live, not latched

`timescale 1ns/10ps

module compat_regbank #(
    parameter int unsigned UPDATE_PERIOD = regmap_pkg::UPDATE_CYCLES // refresh cycles
) (
    input  wire logic        clk_i,             // core clock
    input  wire logic        rst_i,             // synchronous reset, high
    input  wire logic        rd_req_i,          // read strobe, one cycle
    input  wire logic        wr_req_i,          // write strobe, one cycle
    input  wire logic [15:0] reg_addr_i,        // register number
    input  wire logic [15:0] wr_data_i,         // write word, never stored
    input  wire logic [15:0] layout_sel_i,      // register-type setting
    input  wire logic [15:0] slave_addr_i,      // node address
    input  wire logic [15:0] link_set_i,        // serial link settings word
    input  wire logic [15:0] comp_irr_w_i,      // compensated, W/m2
    input  wire logic [15:0] raw_irr_w_i,       // uncorrected, W/m2
    input  wire logic [15:0] supply_dv_i,       // supply, 0.1 V
    input  wire logic [31:0] det_cuv_i,         // detector, 0.01 uV
    input  wire logic [31:0] comp_irr_cw_i,     // compensated, 0.01 W/m2
    input  wire logic [31:0] raw_irr_cw_i,      // uncorrected, 0.01 W/m2
    input  wire logic [31:0] det_nv_i,          // detector, nV
    input  wire logic [127:0] sensor_name_i,    // 16 ASCII chars, char 0 high
    input  wire logic [31:0] sensitivity_i,     // calibration factor
    input  wire logic [31:0] cal_date_i,        // calibration date
    output logic             rd_valid_o,        // read answer, one cycle
    output logic      [15:0] rd_data_o,         // read word
    output logic             wr_ignored_o,      // write dropped, one cycle
    output logic             refresh_o          // snapshot taken, one cycle
);

    // ************************************************************
    // refresh timer
    // ************************************************************
    logic [31:0] tick_cnt_reg;                  // cycles since last refresh
    logic [31:0] tick_cnt_next;                 // next count
    wire         tick;                          // refresh instant

    // RULE_01 periodic refresh timer
    assign tick          = (tick_cnt_reg == UPDATE_PERIOD - 32'd1);
    assign tick_cnt_next = tick ? 32'd0 : tick_cnt_reg + 32'd1;

    // count the refresh period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 32'd0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ************************************************************
    // measurement snapshot
    // ************************************************************
    logic [15:0] comp_w_reg;                    // compensated, W/m2
    logic [15:0] raw_w_reg;                     // uncorrected, W/m2
    logic [15:0] supply_reg;                    // supply voltage
    logic [31:0] det_cuv_reg;                   // detector, 0.01 uV
    logic [31:0] comp_cw_reg;                   // compensated, 0.01 W/m2
    logic [31:0] raw_cw_reg;                    // uncorrected, 0.01 W/m2
    logic [31:0] det_nv_reg;                    // detector, nV

    // RULE_02 RULE_14 whole-sample latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comp_w_reg  <= regmap_pkg::ZERO16;
            raw_w_reg   <= regmap_pkg::ZERO16;
            supply_reg  <= regmap_pkg::ZERO16;
            det_cuv_reg <= regmap_pkg::ZERO32;
            comp_cw_reg <= regmap_pkg::ZERO32;
            raw_cw_reg  <= regmap_pkg::ZERO32;
            det_nv_reg  <= regmap_pkg::ZERO32;
        end else if (tick) begin
            // all words change in the same edge
            comp_w_reg  <= comp_irr_w_i;
            raw_w_reg   <= raw_irr_w_i;
            supply_reg  <= supply_dv_i;
            det_cuv_reg <= det_cuv_i;
            comp_cw_reg <= comp_irr_cw_i;
            raw_cw_reg  <= raw_irr_cw_i;
            det_nv_reg  <= det_nv_i;
        end
    end

    // ************************************************************
    // read decode
    // ************************************************************

    // first compatible layout, registers 0-49
    // RULE_08 RULE_09 RULE_10 first layout decode
    function automatic logic [15:0] alt1_word(
        input logic [15:0] a,
        input logic [15:0] comp,
        input logic [15:0] raw,
        input logic [15:0] sup,
        input logic [31:0] det,
        input logic [15:0] node
    );
        logic [15:0] w;
        w = regmap_pkg::ZERO16;
        unique case (a)
            regmap_pkg::A1_CONST_A_IDX: w = regmap_pkg::A1_CONST_A_VAL;
            regmap_pkg::A1_CONST_B_IDX: w = regmap_pkg::A1_CONST_B_VAL;
            regmap_pkg::A1_CONST_C_IDX: w = regmap_pkg::A1_CONST_C_VAL;
            regmap_pkg::A1_CONST_E_IDX: w = regmap_pkg::A1_CONST_E_VAL;
            regmap_pkg::A1_COMP_IDX:    w = comp;
            regmap_pkg::A1_RAW_IDX:     w = raw;
            regmap_pkg::A1_SUPPLY_IDX:  w = sup;
            regmap_pkg::A1_DET_HI_IDX:  w = det[31:16];
            regmap_pkg::A1_DET_LO_IDX:  w = det[15:0];
            regmap_pkg::A1_YEAR_IDX:    w = regmap_pkg::A1_YEAR_VAL;
            regmap_pkg::A1_FW_IDX:      w = regmap_pkg::FW_REV_VAL;
            regmap_pkg::A1_HW_IDX:      w = regmap_pkg::HW_REV_VAL;
            regmap_pkg::A1_ADDR_IDX:    w = node;
            // fixed zeros and reserved words
            default:                    w = regmap_pkg::ZERO16;
        endcase
        return w;
    endfunction

    // second compatible layout, registers 0-49
    // RULE_11 second layout decode
    function automatic logic [15:0] alt2_word(
        input logic [15:0]  a,
        input logic [15:0]  node,
        input logic [15:0]  link,
        input logic [31:0]  comp,
        input logic [31:0]  raw,
        input logic [31:0]  det,
        input logic [127:0] name,
        input logic [31:0]  sens,
        input logic [31:0]  cal
    );
        logic [15:0] w;
        logic [2:0]  slot;
        w    = regmap_pkg::ZERO16;
        slot = a[2:0];
        unique case (a)
            regmap_pkg::A2_ADDR_IDX:    w = node;
            regmap_pkg::A2_LINK_IDX:    w = link;
            regmap_pkg::A2_COMP_HI_IDX: w = comp[31:16];
            regmap_pkg::A2_COMP_LO_IDX: w = comp[15:0];
            regmap_pkg::A2_RAW_HI_IDX:  w = raw[31:16];
            regmap_pkg::A2_RAW_LO_IDX:  w = raw[15:0];
            regmap_pkg::A2_HUND_A_IDX:  w = regmap_pkg::A2_HUNDRED_VAL;
            regmap_pkg::A2_HUND_B_IDX:  w = regmap_pkg::A2_HUNDRED_VAL;
            regmap_pkg::A2_DET_HI_IDX:  w = det[31:16];
            regmap_pkg::A2_DET_LO_IDX:  w = det[15:0];
            regmap_pkg::A2_SENS_HI_IDX: w = sens[31:16];
            regmap_pkg::A2_SENS_LO_IDX: w = sens[15:0];
            regmap_pkg::A2_CAL_HI_IDX:  w = cal[31:16];
            regmap_pkg::A2_CAL_LO_IDX:  w = cal[15:0];
            default: begin
                // name words 32-39, first pair of chars at 32
                if (a >= regmap_pkg::A2_NAME_FIRST && a <= regmap_pkg::A2_NAME_LAST) begin
                    w = name[127 - 16 * int'(slot) -: 16];
                end else begin
                    w = regmap_pkg::ZERO16;
                end
            end
        endcase
        return w;
    endfunction

    wire [15:0] alt1_rd;                        // first layout word
    wire [15:0] alt2_rd;                        // second layout word
    wire [15:0] layout_rd;                      // selected layout word
    wire [15:0] fixed_rd;                       // word for registers 50 up
    wire [15:0] rd_word;                        // final read word
    wire        in_layout;                      // address within 0-49

    assign alt1_rd = alt1_word(reg_addr_i, comp_w_reg, raw_w_reg, supply_reg,
                               det_cuv_reg, slave_addr_i);
    assign alt2_rd = alt2_word(reg_addr_i, slave_addr_i, link_set_i, comp_cw_reg,
                               raw_cw_reg, det_nv_reg, sensor_name_i,
                               sensitivity_i, cal_date_i);

    // RULE_12 layout chosen by setting
    assign in_layout = (reg_addr_i <= regmap_pkg::LAYOUT_LAST);
    assign layout_rd = (layout_sel_i == regmap_pkg::LAYOUT_ALT1) ? alt1_rd :
                       (layout_sel_i == regmap_pkg::LAYOUT_ALT2) ? alt2_rd :
                       regmap_pkg::ZERO16;

    // RULE_05 RULE_06 RULE_07 fixed upper words
    assign fixed_rd =
        (reg_addr_i == regmap_pkg::MAKER_HI_IDX) ? regmap_pkg::MAKER_NAME_VAL[31:16] :
        (reg_addr_i == regmap_pkg::MAKER_LO_IDX) ? regmap_pkg::MAKER_NAME_VAL[15:0] :
        (reg_addr_i == regmap_pkg::FW_REV_IDX)   ? regmap_pkg::FW_REV_VAL :
        (reg_addr_i == regmap_pkg::HW_REV_IDX)   ? regmap_pkg::HW_REV_VAL :
        regmap_pkg::ZERO16;

    // RULE_04 everything else reads zero
    assign rd_word = in_layout ? layout_rd : fixed_rd;

    // ************************************************************
    // answer registers
    // ************************************************************

    // answer reads one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_valid_o   <= 1'b0;
            rd_data_o    <= regmap_pkg::ZERO16;
            wr_ignored_o <= 1'b0;
            refresh_o    <= 1'b0;
        end else begin
            rd_valid_o   <= rd_req_i;
            // hold last word when idle
            rd_data_o    <= rd_req_i ? rd_word : rd_data_o;
            // RULE_13 writes only reported, never stored
            wr_ignored_o <= wr_req_i;
            refresh_o    <= tick;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_refresh_period;
        @(posedge clk_i) disable iff (rst_i)
        refresh_o |-> $past(tick_cnt_reg) == UPDATE_PERIOD - 32'd1;
    endproperty
    a_refresh_period: assert property (p_refresh_period) // RULE_01
        else $error("refresh not at end of period");

    property p_hold_between;
        @(posedge clk_i) disable iff (rst_i)
        !tick |=> $stable(comp_w_reg) && $stable(det_nv_reg) && $stable(raw_cw_reg);
    endproperty
    a_hold_between: assert property (p_hold_between) // RULE_02
        else $error("snapshot changed between refreshes");

    property p_unused_zero;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && reg_addr_i > regmap_pkg::HW_REV_IDX |=> rd_valid_o && rd_data_o == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // RULE_04
        else $error("unassigned address not zero");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && reg_addr_i >= regmap_pkg::RSV_FIRST && reg_addr_i <= regmap_pkg::RSV_LAST
        |=> rd_data_o == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE_05
        else $error("reserved register not zero");

    property p_maker;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && reg_addr_i == regmap_pkg::MAKER_LO_IDX |=> rd_data_o[7:0] == 8'h20;
    endproperty
    a_maker: assert property (p_maker) // RULE_06
        else $error("maker name last char not space");

    property p_revisions;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && (reg_addr_i == regmap_pkg::FW_REV_IDX
                     || reg_addr_i == regmap_pkg::HW_REV_IDX)
        |=> rd_data_o == (($past(reg_addr_i) == regmap_pkg::FW_REV_IDX) ?
                          regmap_pkg::FW_REV_VAL : regmap_pkg::HW_REV_VAL);
    endproperty
    a_revisions: assert property (p_revisions) // RULE_07
        else $error("revision words wrong");

    property p_alt1_const;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1 && reg_addr_i == 16'h0000
        |=> rd_data_o == 16'hffff;
    endproperty
    a_alt1_const: assert property (p_alt1_const) // RULE_08
        else $error("first layout register 0 wrong");

    property p_alt1_meas;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1 && reg_addr_i == 16'h0005
        |=> rd_data_o == $past(comp_w_reg);
    endproperty
    a_alt1_meas: assert property (p_alt1_meas) // RULE_09
        else $error("first layout irradiance wrong");

    property p_alt1_year;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1 && reg_addr_i == 16'h0029
        |=> rd_data_o == 16'h07e4;
    endproperty
    a_alt1_year: assert property (p_alt1_year) // RULE_10
        else $error("first layout year wrong");

    property p_alt2_hundred;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT2 && reg_addr_i == 16'h0008
        |=> rd_data_o == 16'h0064;
    endproperty
    a_alt2_hundred: assert property (p_alt2_hundred) // RULE_11
        else $error("second layout constant wrong");

    property p_layout_other;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i != regmap_pkg::LAYOUT_ALT1
        && layout_sel_i != regmap_pkg::LAYOUT_ALT2 && reg_addr_i == 16'h0000
        |=> rd_data_o == 16'h0000;
    endproperty
    a_layout_other: assert property (p_layout_other) // RULE_12
        else $error("other layout not zero");

    property p_write_none;
        @(posedge clk_i) disable iff (rst_i)
        wr_req_i && !rd_req_i |=> wr_ignored_o && !rd_valid_o && $stable(rd_data_o);
    endproperty
    a_write_none: assert property (p_write_none) // RULE_13
        else $error("write changed answer");

    property p_pair_latch;
        @(posedge clk_i) disable iff (rst_i)
        tick |=> det_cuv_reg == $past(det_cuv_i) && comp_cw_reg == $past(comp_irr_cw_i);
    endproperty
    a_pair_latch: assert property (p_pair_latch) // RULE_14
        else $error("two-word value not latched whole");

    property p_alt1_supply;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1
        && reg_addr_i == regmap_pkg::A1_SUPPLY_IDX |=> rd_data_o == $past(supply_reg);
    endproperty
    a_alt1_supply: assert property (p_alt1_supply) // RULE_09
        else $error("first layout supply word wrong");

    property p_alt1_det_lo;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1
        && reg_addr_i == regmap_pkg::A1_DET_LO_IDX |=> rd_data_o == $past(det_cuv_reg[15:0]);
    endproperty
    a_alt1_det_lo: assert property (p_alt1_det_lo) // RULE_09
        else $error("first layout detector low word wrong");

    property p_alt1_node;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT1
        && reg_addr_i == regmap_pkg::A1_ADDR_IDX |=> rd_data_o == $past(slave_addr_i);
    endproperty
    a_alt1_node: assert property (p_alt1_node) // RULE_10
        else $error("first layout node address wrong");

    property p_alt2_node;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT2
        && reg_addr_i == regmap_pkg::A2_ADDR_IDX |=> rd_data_o == $past(slave_addr_i);
    endproperty
    a_alt2_node: assert property (p_alt2_node) // RULE_11
        else $error("second layout node address wrong");

    property p_alt2_comp_hi;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i && layout_sel_i == regmap_pkg::LAYOUT_ALT2
        && reg_addr_i == regmap_pkg::A2_COMP_HI_IDX |=> rd_data_o == $past(comp_cw_reg[31:16]);
    endproperty
    a_alt2_comp_hi: assert property (p_alt2_comp_hi) // RULE_11
        else $error("second layout irradiance high word wrong");

    property p_idle_hold;
        @(posedge clk_i) disable iff (rst_i)
        !rd_req_i |=> !rd_valid_o && $stable(rd_data_o);
    endproperty
    a_idle_hold: assert property (p_idle_hold) // RULE_02
        else $error("answer changed without a read");

endmodule

//--- bench/host_model.sv
// Purpose: fieldbus host stand-in issuing register read and write strobes
// Assumes: strobes last one cycle and change 1 ns after the rising edge
// Notes:   drives the bank's request pins through its tasks

`timescale 1ns/10ps

module host_model (
    input  wire logic        clk_i,    // core clock
    output logic             rd_req_o, // read strobe
    output logic             wr_req_o, // write strobe
    output logic      [15:0] addr_o,   // register number
    output logic      [15:0] data_o    // write word
);
    initial begin
        rd_req_o = 1'b0;
        wr_req_o = 1'b0;
        addr_o   = 16'h0000;
        data_o   = 16'h0000;
    end

    // one request per call
    // each call waits for an edge before raising its strobe, never two strobes in one step
    task automatic req(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        rd_req_o = !wr;
        wr_req_o = wr;
        addr_o   = a;
        data_o   = d;
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b0;
        wr_req_o = 1'b0;
        addr_o   = ~a;
    endtask
endmodule

//--- bench/tb_compat_regbank.sv
// Purpose: self-checking bench of the compatible register bank
// Assumes: refresh period shortened to 16 cycles
// Notes:   answers are judged in the cycle in which they stand

`timescale 1ns/10ps

module tb_compat_regbank;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        rd_req, wr_req, rd_valid_o, wr_ignored_o, refresh_o;
    logic [15:0] addr, wdata, rd_data_o;
    logic [15:0] sel = 16'h0001;
    logic [15:0] comp_w = 16'h0123;
    logic [31:0] det = 32'h1234_5678;
    logic [15:0] node = 16'h0011;
    logic [15:0] raw_w = 16'h0456;
    logic [15:0] supply = 16'h00f0;
    logic [31:0] comp_cw = 32'h0001_e240;
    logic [31:0] det_nv = 32'hfedc_ba98;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #10 clk_i = ~clk_i;

    host_model u_host (.clk_i(clk_i), .rd_req_o(rd_req), .wr_req_o(wr_req),
        .addr_o(addr), .data_o(wdata));

    compat_regbank #(.UPDATE_PERIOD(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .rd_req_i(rd_req), .wr_req_i(wr_req), .reg_addr_i(addr), .wr_data_i(wdata),
        .layout_sel_i(sel), .slave_addr_i(node), .link_set_i(16'h0022),
        .comp_irr_w_i(comp_w), .raw_irr_w_i(raw_w), .supply_dv_i(supply),
        .det_cuv_i(det), .comp_irr_cw_i(comp_cw), .raw_irr_cw_i(32'h0002_0000),
        .det_nv_i(det_nv), .sensor_name_i(128'h4142_4344_4546_4748_494a_4b4c_4d4e_4f50),
        .sensitivity_i(32'h0000_4e20), .cal_date_i(32'h0134_5a2d),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_ignored_o(wr_ignored_o),
        .refresh_o(refresh_o));

    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // read one register and judge the answer
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        u_host.req(1'b0, a, 16'h0000);
        chk({rd_valid_o, rd_data_o}, {1'b1, e});
    endtask

    // wait for the refresh pulse, bounded
    task automatic wait_ref;
        int k;
        k = 0;
        while (refresh_o !== 1'b1 && k < 40) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(refresh_o, 1'b1);
    endtask

    // walk a table of addresses under one layout setting
    task automatic table_chk(input logic [15:0] s, input logic [15:0] a[], input logic [15:0] e[]);
        sel = s;
        foreach (a[i]) rd(a[i], e[i]);
    endtask

    task automatic summarize;
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // cycle ceiling against hangs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        int n;
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        wait_ref();
        table_chk(16'h0001, '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 17, 18, 19, 20, 34, 35, 41, 42, 43,
            44, 45, 49}, '{16'hffff, 16'h0064, 1, 0, 1, 16'h0123, 16'h0456, 0, 0, 16'h00f0, 0, 0,
            16'h1234, 16'h5678, 0, 0, 0, 16'h07e4, 0, 1, 1, 16'h0011, 0});
        table_chk(16'h0002, '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 32, 39, 40, 41, 42, 46, 47,
            48}, '{16'h0011, 16'h0022, 1, 16'he240, 2, 0, 0, 0, 16'h0064, 16'h0064, 16'hfedc,
            16'hba98, 0, 16'h4142, 16'h4f50, 0, 0, 16'h4e20, 16'h0134, 16'h5a2d, 0});
        table_chk(16'h0001, '{50, 95, 96, 97, 98, 99, 100}, '{0, 0, 16'h4142, 16'h4320, 1, 1,
            0});
        table_chk(16'h0000, '{0, 5}, '{0, 0});
        sel = 16'h0001;
        u_host.req(1'b1, 16'h0005, 16'hffff);
        chk(wr_ignored_o, 1'b1);
        rd(16'h0005, 16'h0123);
        wait_ref();
        comp_w = 16'h0321;
        det = 32'h8765_4321;
        raw_w = 16'h0654;
        supply = 16'h00e1;
        comp_cw = 32'h0003_0004;
        det_nv = 32'h0506_0708;
        node = 16'h0033;
        rd(16'h0006, 16'h0456);
        rd(16'h0005, 16'h0123);
        rd(16'h0005, 16'h0123);
        wait_ref();
        rd(16'h0005, 16'h0321);
        rd(16'h0012, 16'h8765);
        rd(16'h0013, 16'h4321);
        table_chk(16'h0001, '{6, 9, 45}, '{16'h0654, 16'h00e1, 16'h0033});
        table_chk(16'h0002, '{0, 2, 3, 10, 11}, '{16'h0033, 16'h0003, 16'h0004, 16'h0506,
            16'h0708});
        wait_ref();
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (refresh_o !== 1'b1 && n < 40);
        chk(n, 16);
        summarize();
    end
endmodule
